// ---- rtl/readback_alert_pkg.sv ----
package readback_alert_pkg;
    localparam logic [7:0] cmd_write = 8'h90;
    localparam logic [7:0] cmd_read = 8'h91;
    localparam logic [5:0] ptr_first = 6'h00;
    localparam logic [5:0] ptr_last = 6'h3f;
    localparam logic [3:0] bits_per_byte = 4'h8;
    localparam int n_events = 7;
    localparam logic [2:0] alert_polarity_bit = 3'h6;
    localparam logic [2:0] alert_disable_bit = 3'h5;
    localparam logic [7:0] ctrl1_reset = 8'h00;
    localparam logic [6:0] ara_address = 7'h0c;
endpackage : readback_alert_pkg

// ---- rtl/alert_event_latch.sv ----
`timescale 1ns/100ps
// one sticky event flag, released only after a read and a return within limits
module alert_event_latch (
    input wire logic clk, // system clock
    input wire logic rst_n, // synchronised reset
    input wire logic out_of_limit, // live comparison result
    input wire logic status_read, // status register read pulse
    output logic flag // sticky event flag
);
    typedef struct packed {
        logic flag;
        logic seen_read;
    } latch_state_t;
    latch_state_t s_r, s_nxt;

    always_comb begin
        s_nxt = s_r;
        if (status_read && s_r.flag) begin
            s_nxt.seen_read = 1'b1;
        end
        if (s_r.flag && (s_r.seen_read || status_read) && !out_of_limit) begin
            s_nxt.flag = 1'b0;
            s_nxt.seen_read = 1'b0;
        end
        // a new excursion wins over a clear in the same cycle
        if (out_of_limit) begin
            s_nxt.flag = 1'b1;
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            s_r <= '0;
        end else begin
            s_r <= s_nxt;
        end
    end

    assign flag = s_r.flag;

    property p_event_sets;
        @(posedge clk) disable iff (!rst_n) out_of_limit |=> flag;
    endproperty
    a_event_sets: assert property (p_event_sets) else $error("event not latched");

    property p_hold_until_read;
        @(posedge clk) disable iff (!rst_n)
            (flag && !status_read && !s_r.seen_read) |=> flag;
    endproperty
    a_hold_until_read: assert property (p_hold_until_read) else $error("flag lost w/o read");
endmodule : alert_event_latch

// ---- rtl/serial_readback_limit_alert.sv ----
`timescale 1ns/100ps
module serial_readback_limit_alert
    import readback_alert_pkg::*;
(
    input wire logic clk, // 10 mhz system clock
    input wire logic nrst, // async reset, active low
    input wire logic sclk, // serial clock from host
    input wire logic cs_n, // chip select, active low
    input wire logic din, // serial data in
    output logic dout, // serial data out
    output logic dout_oe, // dout driven when high
    output logic [5:0] reg_addr, // register being fetched
    input wire logic [7:0] reg_rdata, // register contents at reg_addr
    input wire logic [7:0] ctrl1, // control configuration 1
    input wire logic [n_events-1:0] out_of_limit, // live limit comparisons
    input wire logic [n_events-1:0] status_read, // status read pulses per event
    input wire logic two_wire_sel, // two-wire bus interface selected
    input wire logic ara_answered, // response to ara sent, one pulse
    input wire logic ara_lost, // arbitration lost during ara answer
    input wire logic [6:0] bus_address, // own two-wire address
    output logic [7:0] ara_byte, // byte returned to ara read
    output logic [n_events-1:0] event_status, // sticky event flags
    output logic alert_out, // alert pin drive level
    output logic alert_oe // alert pin pulled low when high
);
    typedef enum {st_idle, st_cmd, st_addr, st_read, st_skip} phase_t;

    typedef struct packed {
        logic [1:0] rst_sync;
        logic [2:0] sclk_s;
        logic [1:0] cs_s;
        logic [1:0] din_s;
        phase_t phase;
        logic [3:0] cnt;
        logic [7:0] shreg;
        logic [5:0] ptr;
        logic dout;
        logic dout_oe;
        logic alert_pend;
        logic alert_out;
        logic alert_oe;
        logic [7:0] ara_byte;
        logic [n_events-1:0] status;
    } top_state_t;

    top_state_t s_r, s_nxt;
    logic rst_n;
    logic [n_events-1:0] flags;
    logic sclk_rise, sclk_fall, cs_n_q, any_flag, asserted;

    function automatic logic [5:0] ptr_next(input logic [5:0] p);
        ptr_next = (p == ptr_last) ? ptr_first : p + 6'h01;
    endfunction : ptr_next

    assign rst_n = s_r.rst_sync[1];

    ////////////////////////////////////////////////////////////////////
    genvar gi;
    generate
        for (gi = 0; gi < n_events; gi++) begin : g_ev
            alert_event_latch u_latch (
                .clk(clk),
                .rst_n(rst_n),
                .out_of_limit(out_of_limit[gi]),
                .status_read(status_read[gi]),
                .flag(flags[gi])
            );
        end
    endgenerate

    ////////////////////////////////////////////////////////////////////
    // only the second and third synchroniser stages feed edge detection
    assign sclk_rise = s_r.sclk_s[1] && !s_r.sclk_s[2];
    assign sclk_fall = !s_r.sclk_s[1] && s_r.sclk_s[2];
    assign cs_n_q = s_r.cs_s[1];
    assign any_flag = |flags;

    always_comb begin
        s_nxt = s_r;
        s_nxt.rst_sync = {s_r.rst_sync[0], 1'b1};
        s_nxt.sclk_s = {s_r.sclk_s[1:0], sclk};
        s_nxt.cs_s = {s_r.cs_s[0], cs_n};
        s_nxt.din_s = {s_r.din_s[0], din};
        s_nxt.status = flags;
        if (cs_n_q) begin
            s_nxt.phase = st_idle;
            s_nxt.dout_oe = 1'b0;
            s_nxt.dout = 1'b0;
        end else begin
            case (s_r.phase)
                st_idle: begin
                    // a start is only seen on the falling select edge
                    s_nxt.phase = st_cmd;
                    s_nxt.cnt = 4'h0;
                    s_nxt.dout_oe = 1'b1;
                end
                st_cmd, st_addr: begin
                    if (sclk_rise) begin
                        s_nxt.shreg = {s_r.shreg[6:0], s_r.din_s[1]};
                        s_nxt.cnt = s_r.cnt + 4'h1;
                        if (s_r.cnt == bits_per_byte - 4'h1) begin
                            s_nxt.cnt = 4'h0;
                            if (s_r.phase == st_addr) begin
                                s_nxt.ptr = {s_r.shreg[4:0], s_r.din_s[1]};
                                s_nxt.phase = st_skip;
                            end else if ({s_r.shreg[6:0], s_r.din_s[1]} == cmd_read) begin
                                s_nxt.phase = st_read;
                                s_nxt.shreg = reg_rdata;
                            end else if ({s_r.shreg[6:0], s_r.din_s[1]} == cmd_write) begin
                                s_nxt.phase = st_addr;
                            end else begin
                                s_nxt.phase = st_skip;
                            end
                        end
                    end
                end
                st_read: begin
                    if (sclk_fall) begin
                        s_nxt.dout = s_r.shreg[7];
                        s_nxt.shreg = {s_r.shreg[6:0], 1'b0};
                        s_nxt.cnt = s_r.cnt + 4'h1;
                        if (s_r.cnt == bits_per_byte - 4'h1) begin
                            s_nxt.cnt = 4'h0;
                            s_nxt.ptr = ptr_next(s_r.ptr);
                        end
                    end
                    // reload after the last bit went out, before the next falling edge
                    if (sclk_rise && s_r.cnt == 4'h0) begin
                        s_nxt.shreg = reg_rdata;
                    end
                end
                st_skip: begin
                    s_nxt.phase = st_skip;
                end
                default: begin
                    s_nxt.phase = st_idle;
                end
            endcase
        end
        // alert level: pending until the latches have cleared and, in two-wire mode only, the ara is answered
        if (any_flag) begin
            s_nxt.alert_pend = 1'b1;
        end else if (!two_wire_sel || ara_answered || !s_r.alert_pend) begin
            s_nxt.alert_pend = 1'b0;
        end
        if (two_wire_sel && ara_lost) begin
            s_nxt.alert_pend = 1'b1;
        end
        s_nxt.ara_byte = {bus_address, 1'b1};
        // open drain: active low pulls, active high releases when asserted
        s_nxt.alert_out = 1'b0;
        if (ctrl1[alert_disable_bit]) begin
            s_nxt.alert_oe = 1'b0;
        end else if (ctrl1[alert_polarity_bit] && !two_wire_sel) begin
            s_nxt.alert_oe = !s_nxt.alert_pend;
        end else begin
            s_nxt.alert_oe = s_nxt.alert_pend;
        end
    end

    assign asserted = s_r.alert_pend;

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            s_r <= '0;
            s_r.ptr <= ptr_first;
            s_r.phase <= st_idle;
            s_r.cs_s <= 2'h3;
            // sclk idles high: a cleared history would fake a rising edge after reset
            s_r.sclk_s <= 3'h7;
        end else begin
            s_r <= s_nxt;
        end
    end

    assign dout = s_r.dout;
    assign dout_oe = s_r.dout_oe;
    assign reg_addr = s_r.ptr;
    assign ara_byte = s_r.ara_byte;
    assign event_status = s_r.status;
    assign alert_out = s_r.alert_out;
    assign alert_oe = s_r.alert_oe;

    ////////////////////////////////////////////////////////////////////
    property p_float_deselected;
        @(posedge clk) disable iff (!rst_n) cs_n_q |=> !dout_oe;
    endproperty
    a_float_deselected: assert property (p_float_deselected) else $error("dout driven");

    property p_dout_on_fall;
        @(posedge clk) disable iff (!rst_n)
            (!sclk_fall && !cs_n_q) |=> $stable(dout);
    endproperty
    a_dout_on_fall: assert property (p_dout_on_fall) else $error("dout moved off fall");

    property p_ptr_wrap;
        @(posedge clk) disable iff (!rst_n)
            (s_r.phase == st_read && sclk_fall && s_r.cnt == 4'h7 && !cs_n_q
             && s_r.ptr == ptr_last) |=> reg_addr == ptr_first;
    endproperty
    a_ptr_wrap: assert property (p_ptr_wrap) else $error("pointer wrap wrong");

    property p_disable;
        @(posedge clk) disable iff (!rst_n) ctrl1[alert_disable_bit] |=> !alert_oe;
    endproperty
    a_disable: assert property (p_disable) else $error("alert not disabled");

    property p_active_low;
        @(posedge clk) disable iff (!rst_n)
            (!ctrl1[alert_disable_bit] && !ctrl1[alert_polarity_bit] && any_flag)
            |=> alert_oe && !alert_out;
    endproperty
    a_active_low: assert property (p_active_low) else $error("alert not pulled");

    property p_ara_byte;
        @(posedge clk) disable iff (!rst_n) ##1 ara_byte == {$past(bus_address), 1'b1};
    endproperty
    a_ara_byte: assert property (p_ara_byte) else $error("ara byte wrong");

    property p_hold_unanswered;
        @(posedge clk) disable iff (!rst_n)
            (two_wire_sel && asserted && !ara_answered) |=> asserted;
    endproperty
    a_hold_unanswered: assert property (p_hold_unanswered) else $error("released early");

    property p_status_mirror;
        @(posedge clk) disable iff (!rst_n) ##1 event_status == $past(flags);
    endproperty
    a_status_mirror: assert property (p_status_mirror) else $error("status mismatch");
endmodule : serial_readback_limit_alert

// ---- tb/spi_host_model.sv ----
`timescale 1ns/100ps
module spi_host_model (
    input wire logic clk, // system clock paces every step
    output logic sclk, // serial clock, idles high, still between frames
    output logic cs_n, // chip select
    output logic din, // data to device
    input wire logic dout, // data from device
    output logic [7:0] late // dout moves seen while sclk high
);
    initial begin
        sclk = 1'b1;
        cs_n = 1'b1;
        din = 1'b0;
        late = 8'h00;
    end
    task automatic step(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask : step
    // command byte, then n bytes written or read; one sclk period is 8 clk
    task automatic frame(input logic [7:0] cmd, input logic [7:0] wb, input int n,
                         output logic [23:0] got);
        logic [15:0] sh;
        logic s;
        sh = {cmd, wb};
        got = 24'h000000;
        step(1);
        cs_n = 1'b0;
        step(4);
        for (int i = 0; i < 8 + 8 * n; i++) begin
            sclk = 1'b0;
            // after the command byte of anything but a write, din is not ours, so it toggles instead of holding
            din = (i < 8 || cmd == 8'h90) ? sh[15] : ~din;
            sh = sh << 1;
            step(4);
            sclk = 1'b1;
            s = dout;
            step(4);
            if (dout !== s) late = late + 8'h01;
            if (i >= 8) got = {got[22:0], s};
        end
        cs_n = 1'b1;
        din = ~din;
        step(4);
    endtask : frame
endmodule : spi_host_model

// ---- tb/tb_serial_readback_limit_alert.sv ----
`timescale 1ns/100ps
module tb_serial_readback_limit_alert;
    import readback_alert_pkg::*;
    logic clk = 1'b0;
    logic nrst = 1'b0;
    logic sclk, cs_n, din, dout, dout_oe, tws, ans, lost, alert_out, alert_oe;
    logic [5:0] reg_addr;
    logic [7:0] reg_rdata, ctrl1, ara_byte, late;
    logic [6:0] bus_address;
    logic [n_events-1:0] ool, sr, event_status;
    logic [23:0] got;
    int n_mismatch = 0;
    int checked = 0;
    always #50 clk = ~clk;
    function automatic logic [7:0] regval(input logic [5:0] a);
        return {2'h2, a} ^ 8'h5a;
    endfunction : regval
    assign reg_rdata = regval(reg_addr);
    serial_readback_limit_alert u_dut (.clk(clk), .nrst(nrst), .sclk(sclk), .cs_n(cs_n),
        .din(din), .dout(dout), .dout_oe(dout_oe), .reg_addr(reg_addr),
        .reg_rdata(reg_rdata), .ctrl1(ctrl1), .out_of_limit(ool), .status_read(sr),
        .two_wire_sel(tws), .ara_answered(ans), .ara_lost(lost),
        .bus_address(bus_address), .ara_byte(ara_byte), .event_status(event_status),
        .alert_out(alert_out), .alert_oe(alert_oe));
    // the data line has a pull-up, so a released pin reads high at the host
    spi_host_model u_host (.clk(clk), .sclk(sclk), .cs_n(cs_n), .din(din),
        .dout(dout_oe ? dout : 1'b1), .late(late));
    ////////////////////////////////////////////////////////////////////////////////
    task automatic tick(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask : tick
    task automatic chk_data(input logic [23:0] g, input logic [23:0] e);
        checked++;
        if (g !== e) begin
            n_mismatch++;
            $display("BAD %0t data got %h exp %h", $time, g, e);
        end
    endtask : chk_data
    task automatic chk_flag(input logic [7:0] g, input logic [7:0] e);
        checked++;
        if (g !== e) begin
            n_mismatch++;
            $display("BAD %0t flag got %h exp %h", $time, g, e);
        end
    endtask : chk_flag
    task automatic wait_oe(input logic v);
        for (int i = 0; i < 10 && alert_oe !== v; i++) tick(1);
    endtask : wait_oe
    task automatic pulse_read(input int i);
        sr = n_events'(1) << i;
        tick(1);
        sr = '0;
        tick(3);
    endtask : pulse_read
    task automatic end_sim;
        $display("mismatches %0d checks %0d", n_mismatch, checked);
        if (n_mismatch == 0 && checked > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask : end_sim
    ////////////////////////////////////////////////////////////////////////////////
    // whole run is about 800 clk; far margin
    initial begin
        #2000000;
        n_mismatch++;
        end_sim();
    end
    initial begin
        {ool, sr, tws, ans, lost} = '0;
        ctrl1 = ctrl1_reset;
        bus_address = 7'h2c;
        tick(2);
        nrst = 1'b1;
        tick(6);
        chk_flag({alert_oe, dout_oe, 6'h00}, 8'h00);
        u_host.frame(cmd_write, 8'h3e, 1, got);
        u_host.frame(cmd_read, 8'h00, 3, got);
        chk_data(got, {regval(6'h3e), regval(6'h3f), regval(6'h00)});
        u_host.frame(8'h92, 8'h10, 1, got);
        u_host.frame(cmd_read, 8'h00, 1, got);
        chk_data(got, {16'h0000, regval(6'h01)});
        chk_flag(late, 8'h00);
        chk_flag({7'h00, dout_oe}, 8'h00);
        for (int i = 0; i < n_events; i++) begin
            ool = n_events'(1) << i;
            wait_oe(1'b1);
            chk_flag({alert_out, alert_oe, 6'h00}, 8'h40);
            chk_flag(8'(event_status), 8'(ool));
            pulse_read(i);
            chk_flag({7'h00, alert_oe}, 8'h01);
            ool = '0;
            tick(3);
            pulse_read(i);
            wait_oe(1'b0);
            chk_flag({alert_oe, 7'(event_status)}, 8'h00);
        end
        ctrl1 = 8'h20;
        ool = 7'h01;
        tick(5);
        chk_flag({7'h00, alert_oe}, 8'h00);
        ctrl1 = 8'h00;
        wait_oe(1'b1);
        chk_flag({7'h00, alert_oe}, 8'h01);
        ool = '0;
        tick(4);
        chk_flag({7'h00, alert_oe}, 8'h01);
        pulse_read(0);
        wait_oe(1'b0);
        // active high: pin is let go while asserted
        ctrl1 = 8'h40;
        tick(3);
        chk_flag({7'h00, alert_oe}, 8'h01);
        ool = 7'h04;
        wait_oe(1'b0);
        chk_flag({7'h00, alert_oe}, 8'h00);
        ool = '0;
        pulse_read(2);
        ctrl1 = 8'h00;
        tws = 1'b1;
        tick(3);
        ool = 7'h02;
        wait_oe(1'b1);
        chk_flag(ara_byte, {bus_address, 1'b1});
        lost = 1'b1;
        tick(1);
        lost = 1'b0;
        tick(4);
        chk_flag({7'h00, alert_oe}, 8'h01);
        // two-wire mode keeps the alert active low whatever the polarity bit says
        ctrl1 = 8'h40;
        tick(2);
        chk_flag({7'h00, alert_oe}, 8'h01);
        ctrl1 = 8'h00;
        ans = 1'b1;
        tick(1);
        ans = 1'b0;
        ool = '0;
        pulse_read(1);
        tick(4);
        chk_flag({7'h00, alert_oe}, 8'h01);
        ans = 1'b1;
        tick(1);
        ans = 1'b0;
        wait_oe(1'b0);
        chk_flag({7'h00, alert_oe}, 8'h00);
        end_sim();
    end
endmodule : tb_serial_readback_limit_alert
